// ### hdl/fmx_pkg.sv
// Constants shared by the float move/load/multiply execute block.
// Assumes a 32-bit register bus with one aligned word per register.
package fmx_pkg;
  // Register byte offsets
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_FCSR   = 8'h04;
  localparam logic [7:0] A_INSTR  = 8'h08;
  localparam logic [7:0] A_GPR_LO = 8'h0C;
  localparam logic [7:0] A_GPR_HI = 8'h10;
  localparam logic [7:0] A_FS_LO  = 8'h14;
  localparam logic [7:0] A_FS_HI  = 8'h18;
  localparam logic [7:0] A_FT_LO  = 8'h1C;
  localparam logic [7:0] A_FT_HI  = 8'h20;
  localparam logic [7:0] A_MEM_LO = 8'h24;
  localparam logic [7:0] A_MEM_HI = 8'h28;
  localparam logic [7:0] A_RES_LO = 8'h2C;
  localparam logic [7:0] A_RES_HI = 8'h30;
  localparam logic [7:0] A_EA_LO  = 8'h34;
  localparam logic [7:0] A_EA_HI  = 8'h38;
  localparam logic [7:0] A_STATUS = 8'h3C;
  // Control register bits
  localparam int CTRL_EN = 0;
  localparam int CTRL_BE = 1;
  localparam int CTRL_RE = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // Cause vector bit positions {E,V,Z,O,U,I}
  localparam int CB_I = 0;
  localparam int CB_U = 1;
  localparam int CB_O = 2;
  localparam int CB_V = 4;
  localparam int CB_E = 5;
  // Rounding modes
  localparam logic [1:0] RM_RN = 2'h0;
  localparam logic [1:0] RM_RZ = 2'h1;
  localparam logic [1:0] RM_RP = 2'h2;
  localparam logic [1:0] RM_RM = 2'h3;
  // Opcode fields
  localparam logic [5:0] OP_LWF = 6'h31;
  localparam logic [5:0] OP_COP = 6'h11;
  localparam logic [4:0] SUB_MF = 5'h00;
  localparam logic [4:0] SUB_MT = 5'h04;
  localparam logic [4:0] FMT_S  = 5'h10;
  localparam logic [4:0] FMT_D  = 5'h11;
  localparam logic [5:0] FN_MUL = 6'h02;
  localparam logic [5:0] FN_MOV = 6'h06;
  localparam logic [5:0] FN_NEG = 6'h07;
  typedef enum logic [2:0] {
    EX_NONE = 3'b000,
    EX_CPU  = 3'b001,
    EX_RI   = 3'b010,
    EX_ADEL = 3'b011,
    EX_FPE  = 3'b100
  } fmx_exc_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01
  } fmx_state_t;
endpackage

// ### hdl/fmx_fmul.sv
// Combinational IEEE multiply for one format, with rounding and flags.
// Assumes the caller registers the result; denormals are not handled.
`timescale 1ns/1ps
module fmx_fmul #(
  parameter int EW = 8,
  parameter int MW = 23
) (
  input  wire logic [EW+MW:0] a,
  input  wire logic [EW+MW:0] b,
  input  wire logic [1:0]     rm,
  output logic      [EW+MW:0] res,
  output logic      [5:0]     flags
);
  import fmx_pkg::*;
  localparam int W  = EW + MW + 1;
  localparam int PW = 2 * MW + 2;
  localparam logic [EW+1:0] BIAS = (EW+2)'((1 << (EW - 1)) - 1);
  localparam logic [EW+1:0] EMAX = (EW+2)'((1 << EW) - 1);

  logic          sr, g, st, inc, huge;
  logic          a_nan, b_nan, a_inf, b_inf;
  logic          a_zero, b_zero, a_den, b_den;
  logic [PW-1:0] ma, mb, prod, pn;
  logic [MW:0]   mr;
  logic [EW+1:0] er;

  // Operand classes
  assign sr     = a[W-1] ^ b[W-1];
  assign a_nan  = (&a[W-2:MW]) && (|a[MW-1:0]);
  assign b_nan  = (&b[W-2:MW]) && (|b[MW-1:0]);
  assign a_inf  = (&a[W-2:MW]) && !(|a[MW-1:0]);
  assign b_inf  = (&b[W-2:MW]) && !(|b[MW-1:0]);
  assign a_zero = !(|a[W-2:0]);
  assign b_zero = !(|b[W-2:0]);
  assign a_den  = !(|a[W-2:MW]) && (|a[MW-1:0]);
  assign b_den  = !(|b[W-2:MW]) && (|b[MW-1:0]);

  // Exact product, then normalise so the leading one sits at the top
  assign ma   = PW'({1'b1, a[MW-1:0]});
  assign mb   = PW'({1'b1, b[MW-1:0]});
  assign prod = ma * mb;
  assign pn   = prod[PW-1] ? prod : (prod << 1);
  assign g    = pn[PW-2-MW];
  assign st   = |pn[PW-3-MW:0];

  // Rounding increment from the current mode
  always_comb
  begin
    case (rm)
      RM_RN:   inc = g && (st || pn[PW-1-MW]);
      RM_RZ:   inc = 1'b0;
      RM_RP:   inc = !sr && (g || st);
      RM_RM:   inc = sr && (g || st);
      default: inc = 1'b0;
    endcase
  end

  assign mr = {1'b0, pn[PW-2 -: MW]} + (MW+1)'(inc);
  // Wraps negative below zero; the top bit then flags underflow
  assign er = {2'b00, a[W-2:MW]} + {2'b00, b[W-2:MW]} - BIAS
            + (EW+2)'(prod[PW-1]) + (EW+2)'(mr[MW]);
  // Overflow clamps to the largest finite value when rounding inward
  assign huge = (rm == RM_RZ) || ((rm == RM_RP) && sr)
             || ((rm == RM_RM) && !sr);

  // Special cases first, then the rounded normal result
  always_comb
  begin
    res   = {sr, er[EW-1:0], (mr[MW] ? {MW{1'b0}} : mr[MW-1:0])};
    flags = 6'h00;
    if (a_nan || b_nan || (a_inf && b_zero) || (a_zero && b_inf))
    begin
      res         = {1'b0, {EW{1'b1}}, 1'b0, {(MW-1){1'b1}}};
      flags[CB_V] = 1'b1;
    end
    else if (a_inf || b_inf)
      res = {sr, {EW{1'b1}}, {MW{1'b0}}};
    else if (a_zero || b_zero)
      res = {sr, {(W-1){1'b0}}};
    else if (a_den || b_den)
      flags[CB_E] = 1'b1;
    else if (!er[EW+1] && (er >= EMAX))
    begin
      res = huge ? {sr, {(EW-1){1'b1}}, 1'b0, {MW{1'b1}}}
                 : {sr, {EW{1'b1}}, {MW{1'b0}}};
      flags[CB_O] = 1'b1;
      flags[CB_I] = 1'b1;
    end
    else if (er[EW+1] || (er == '0))
    begin
      flags[CB_E] = 1'b1;
      flags[CB_U] = 1'b1;
    end
    else
      flags[CB_I] = g || st;
  end
endmodule

// ### hdl/fmx_exec.sv
// Float word load, int/float word moves, float copy, negate, multiply.
// Assumes an AHB-Lite master; operands and memory data come from software.
// Behaviour
// [RQ1] Word load address is base register plus sign-extended 16-bit offset.
// [RQ2] Word load with either low address bit set raises address error.
// [RQ3] Loaded word lands in low half; upper half is undefined.
// [RQ4] Aligned 64-bit fetch; word lane picked by address and endian setting.
// [RQ5] Move float-to-int decodes as opcode 010001, sub-op 00000, zero tail.
// [RQ6] Move float-to-int copies low word, sign-extended to 64 bits.
// [RQ7] Move int-to-float decodes as opcode 010001 with sub-op 00100.
// [RQ8] Move int-to-float writes low word; upper half is undefined.
// [RQ9] Register copy: function 000110, bits 20..16 zero, copies source.
// [RQ10] Register copy never raises any floating-point condition, NaN included.
// [RQ11] Multiply: opcode 010001, function 000010, product to destination.
// [RQ12] Multiply rounds an exact product with the current rounding mode.
// [RQ13] Negate flips only the sign bit; a NaN operand flags invalid.
// [RQ14] Disabled unit gives coprocessor unusable; bad format is reserved.
// [RQ15] Multiply raises inexact, overflow, underflow, invalid, unimplemented.
`timescale 1ns/1ps
module fmx_exec #(
  parameter int AW = 8
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp
);
  import fmx_pkg::*;

  logic          wr_pend_q;
  logic [AW-1:0] waddr_q;
  logic [31:0]   hrdata_q;
  logic          hreadyout_q;
  logic          hresp_q;
  logic [2:0]    ctrl_q;
  logic [1:0]    rm_q;
  logic [4:0]    flags_q;
  logic [5:0]    cause_q, cause_d;
  logic [31:0]   instr_q;
  logic [63:0]   gpr_q, fs_q, ft_q, mem_q;
  logic [63:0]   res_q, res_d, ea_q, ea_d;
  logic          wfpr_q, wfpr_d, wgpr_q, wgpr_d;
  logic [4:0]    dst_q, dst_d;
  logic [2:0]    pad_q, pad_d, bsel;
  fmx_exc_t      exc_q, exc_d;
  fmx_state_t    st_q;
  logic          ex_go, start, is_fp;
  logic [5:0]    f_op, f_fn;
  logic [4:0]    f_sub, f_ft, f_fs, f_fd;
  logic          is_lw, is_cop, is_mf, is_mt, fmt_ok, dbl;
  logic          is_mov, is_neg, is_mul, known, fs_nan;
  logic [31:0]   s_res;
  logic [63:0]   d_res;
  logic [5:0]    s_flg, d_flg;

  // Write strobe for one register in the data phase
  function automatic logic wr_hit(input logic [AW-1:0] a);
    wr_hit = wr_pend_q && (waddr_q == a);
  endfunction

  // Replace one half of a 64-bit operand register
  function automatic logic [63:0] put_word(input logic [63:0] old,
                                           input logic        hi,
                                           input logic [31:0] d);
    put_word = hi ? {d, old[31:0]} : {old[63:32], d};
  endfunction

  // Read mux; unmapped offsets read zero
  function automatic logic [31:0] rd_word(input logic [AW-1:0] a);
    case (a)
      AW'(A_CTRL):   rd_word = {29'h0, ctrl_q};
      AW'(A_FCSR):   rd_word = {14'h0, cause_q, 5'h0, flags_q, rm_q};
      AW'(A_INSTR):  rd_word = instr_q;
      AW'(A_GPR_LO): rd_word = gpr_q[31:0];
      AW'(A_GPR_HI): rd_word = gpr_q[63:32];
      AW'(A_FS_LO):  rd_word = fs_q[31:0];
      AW'(A_FS_HI):  rd_word = fs_q[63:32];
      AW'(A_FT_LO):  rd_word = ft_q[31:0];
      AW'(A_FT_HI):  rd_word = ft_q[63:32];
      AW'(A_MEM_LO): rd_word = mem_q[31:0];
      AW'(A_MEM_HI): rd_word = mem_q[63:32];
      AW'(A_RES_LO): rd_word = res_q[31:0];
      AW'(A_RES_HI): rd_word = res_q[63:32];
      AW'(A_EA_LO):  rd_word = ea_q[31:0];
      AW'(A_EA_HI):  rd_word = ea_q[63:32];
      AW'(A_STATUS): rd_word = {17'h0, pad_q, 1'b0, exc_q, dst_q,
                                wgpr_q, wfpr_q, (st_q != ST_IDLE)};
      default:       rd_word = 32'h0;
    endcase
  endfunction

  // Address phase: latch writes, answer reads in the next data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      waddr_q   <= '0;
      hrdata_q  <= 32'h0;
    end
    else
    begin
      wr_pend_q <= hsel && htrans[1] && hready && hwrite;
      if (hsel && htrans[1] && hready)
      begin
        waddr_q <= haddr[AW-1:0];
        if (!hwrite)
          hrdata_q <= rd_word(haddr[AW-1:0]);
      end
    end
  end

  // Zero wait states and OKAY once out of reset (hreadyout is low during reset), so no stall path exists
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout_q <= 1'b0;
      hresp_q     <= 1'b0;
    end
    else
    begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;

  // Unit enable and endian settings
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_q <= CTRL_RST;
    else if (wr_hit(AW'(A_CTRL)))
      ctrl_q <= hwdata[2:0];
  end

  // Operand and memory-data registers supplied by the pipeline side
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gpr_q <= 64'h0;
      fs_q  <= 64'h0;
      ft_q  <= 64'h0;
      mem_q <= 64'h0;
    end
    else if (wr_pend_q)
    begin
      if (wr_hit(AW'(A_GPR_LO)) || wr_hit(AW'(A_GPR_HI)))
        gpr_q <= put_word(gpr_q, wr_hit(AW'(A_GPR_HI)), hwdata);
      if (wr_hit(AW'(A_FS_LO)) || wr_hit(AW'(A_FS_HI)))
        fs_q <= put_word(fs_q, wr_hit(AW'(A_FS_HI)), hwdata);
      if (wr_hit(AW'(A_FT_LO)) || wr_hit(AW'(A_FT_HI)))
        ft_q <= put_word(ft_q, wr_hit(AW'(A_FT_HI)), hwdata);
      if (wr_hit(AW'(A_MEM_LO)) || wr_hit(AW'(A_MEM_HI)))
        mem_q <= put_word(mem_q, wr_hit(AW'(A_MEM_HI)), hwdata);
    end
  end

  // Writing the instruction starts one execute cycle; ignored while busy
  assign start = wr_hit(AW'(A_INSTR)) && (st_q == ST_IDLE);
  assign ex_go = (st_q == ST_EXEC);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q    <= ST_IDLE;
      instr_q <= 32'h0;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
        begin
          if (start)
          begin
            instr_q <= hwdata;
            st_q    <= ST_EXEC;
          end
        end
        ST_EXEC: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Instruction fields
  assign f_op  = instr_q[31:26];
  assign f_sub = instr_q[25:21];
  assign f_ft  = instr_q[20:16];
  assign f_fs  = instr_q[15:11];
  assign f_fd  = instr_q[10:6];
  assign f_fn  = instr_q[5:0];

  // [RQ5] [RQ7] [RQ9] [RQ11] opcode decode
  assign is_lw  = (f_op == OP_LWF);
  assign is_cop = (f_op == OP_COP);
  assign is_mf  = is_cop && (f_sub == SUB_MF) && (instr_q[10:0] == 11'h000);
  assign is_mt  = is_cop && (f_sub == SUB_MT);
  assign fmt_ok = (f_sub == FMT_S) || (f_sub == FMT_D);
  assign dbl    = (f_sub == FMT_D);
  assign is_mov = is_cop && fmt_ok && (f_fn == FN_MOV) && (f_ft == 5'h00);
  assign is_neg = is_cop && fmt_ok && (f_fn == FN_NEG) && (f_ft == 5'h00);
  assign is_mul = is_cop && fmt_ok && (f_fn == FN_MUL);
  assign known  = is_lw || is_mf || is_mt || is_mov || is_neg || is_mul;
  assign is_fp  = is_mov || is_neg || is_mul;
  assign fs_nan = dbl ? ((&fs_q[62:52]) && (|fs_q[51:0]))
                      : ((&fs_q[30:23]) && (|fs_q[22:0]));

  // [RQ12] one multiplier per format, both fed the current mode
  fmx_fmul #(.EW(8), .MW(23)) u_mul_s (
    .a     (fs_q[31:0]),
    .b     (ft_q[31:0]),
    .rm    (rm_q),
    .res   (s_res),
    .flags (s_flg)
  );

  fmx_fmul #(.EW(11), .MW(52)) u_mul_d (
    .a     (fs_q),
    .b     (ft_q),
    .rm    (rm_q),
    .res   (d_res),
    .flags (d_flg)
  );

  // Execute: exceptions suppress the register write
  always_comb
  begin
    // [RQ1] effective address
    ea_d  = gpr_q + {{48{instr_q[15]}}, instr_q[15:0]};
    // [RQ4] physical low bits and word lane follow the endian settings
    pad_d   = ea_d[2:0] ^ {ctrl_q[CTRL_RE], 2'b00};
    bsel    = ea_d[2:0] ^ {ctrl_q[CTRL_BE], 2'b00};
    res_d   = 64'h0;
    exc_d   = EX_NONE;
    wfpr_d  = 1'b0;
    wgpr_d  = 1'b0;
    dst_d   = f_fd;
    cause_d = 6'h00;
    // [RQ14] disabled unit first, then unknown encodings
    if (!ctrl_q[CTRL_EN] && (is_lw || is_cop))
      exc_d = EX_CPU;
    else if (!known)
      exc_d = EX_RI;
    else if (is_lw)
    begin
      dst_d = f_ft;
      // [RQ2] word alignment check
      if (ea_d[1:0] != 2'b00)
        exc_d = EX_ADEL;
      else
      begin
        // [RQ3] low word only, upper half driven zero
        wfpr_d = 1'b1;
        res_d  = {32'h0, (bsel[2] ? mem_q[63:32] : mem_q[31:0])};
      end
    end
    else if (is_mf)
    begin
      // [RQ6] sign-extended copy into the integer side
      dst_d  = f_ft;
      wgpr_d = 1'b1;
      res_d  = {{32{fs_q[31]}}, fs_q[31:0]};
    end
    else if (is_mt)
    begin
      // [RQ8] low word of the integer source
      dst_d  = f_fs;
      wfpr_d = 1'b1;
      res_d  = {32'h0, gpr_q[31:0]};
    end
    else if (is_mov)
    begin
      // [RQ9] [RQ10] plain copy, cause stays clear
      wfpr_d = 1'b1;
      res_d  = dbl ? fs_q : {32'h0, fs_q[31:0]};
    end
    else if (is_neg)
    begin
      // [RQ13] sign flip; NaN still flags invalid
      wfpr_d        = 1'b1;
      cause_d[CB_V] = fs_nan;
      res_d = dbl ? {~fs_q[63], fs_q[62:0]}
                  : {32'h0, ~fs_q[31], fs_q[30:0]};
    end
    else
    begin
      // [RQ11] [RQ15] product and its conditions
      cause_d = dbl ? d_flg : s_flg;
      res_d   = dbl ? d_res : {32'h0, s_res};
      if (cause_d[CB_E])
        exc_d = EX_FPE;
      else
        wfpr_d = 1'b1;
    end
  end

  // Results and status captured at the end of the execute cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      res_q  <= 64'h0;
      ea_q   <= 64'h0;
      pad_q  <= 3'h0;
      exc_q  <= EX_NONE;
      wfpr_q <= 1'b0;
      wgpr_q <= 1'b0;
      dst_q  <= 5'h00;
    end
    else if (ex_go)
    begin
      res_q  <= res_d;
      ea_q   <= ea_d;
      pad_q  <= pad_d;
      exc_q  <= exc_d;
      wfpr_q <= wfpr_d;
      wgpr_q <= wgpr_d;
      dst_q  <= dst_d;
    end
  end

  // Control/status: sticky flags, hardware set wins over a software write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rm_q    <= RM_RN;
      flags_q <= 5'h00;
      cause_q <= 6'h00;
    end
    else
    begin
      if (wr_hit(AW'(A_FCSR)))
        rm_q <= hwdata[1:0];
      if (ex_go && is_fp && (exc_d != EX_CPU))
      begin
        cause_q <= cause_d;
        flags_q <= (wr_hit(AW'(A_FCSR)) ? hwdata[6:2] : flags_q)
                 | cause_d[4:0];
      end
      else if (wr_hit(AW'(A_FCSR)))
        flags_q <= hwdata[6:2];
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_ea_form;
    ex_go && is_lw |=> ea_q == $past(gpr_q)
      + {{48{$past(instr_q[15])}}, $past(instr_q[15:0])};
  endproperty
  a_ea_form: assert property (p_ea_form) // [RQ1]
    else $error("load address not base plus offset");

  property p_adel;
    ex_go && is_lw && ctrl_q[CTRL_EN]
      |=> ((ea_q[1:0] != 2'b00) == (exc_q == EX_ADEL))
          && ((exc_q == EX_ADEL) != wfpr_q);
  endproperty
  a_adel: assert property (p_adel) // [RQ2]
    else $error("misaligned load not trapped");

  property p_lw_lane;
    ex_go && is_lw && ctrl_q[CTRL_EN] && (ea_d[1:0] == 2'b00)
      |=> res_q == {32'h0, ((ea_q[2] ^ $past(ctrl_q[CTRL_BE]))
                   ? $past(mem_q[63:32]) : $past(mem_q[31:0]))};
  endproperty
  a_lw_lane: assert property (p_lw_lane) // [RQ3] [RQ4]
    else $error("loaded word from wrong lane");

  property p_mf_sext;
    ex_go && is_mf && ctrl_q[CTRL_EN]
      |=> wgpr_q && !wfpr_q
          && res_q == {{32{$past(fs_q[31])}}, $past(fs_q[31:0])};
  endproperty
  a_mf_sext: assert property (p_mf_sext) // [RQ5] [RQ6]
    else $error("float-to-int move wrong");

  property p_mt_low;
    ex_go && is_mt && ctrl_q[CTRL_EN]
      |=> wfpr_q && res_q[31:0] == $past(gpr_q[31:0])
          && dst_q == $past(f_fs);
  endproperty
  a_mt_low: assert property (p_mt_low) // [RQ7] [RQ8]
    else $error("int-to-float move wrong");

  property p_mov_quiet;
    ex_go && is_mov && ctrl_q[CTRL_EN]
      |=> res_q == ($past(dbl) ? $past(fs_q) : {32'h0, $past(fs_q[31:0])})
          && cause_q == 6'h00 && wfpr_q;
  endproperty
  a_mov_quiet: assert property (p_mov_quiet) // [RQ9] [RQ10]
    else $error("copy altered value or raised a flag");

  property p_neg_sign;
    ex_go && is_neg && ctrl_q[CTRL_EN]
      |=> $past(dbl)
          ? (res_q[63] != $past(fs_q[63])
             && res_q[62:0] == $past(fs_q[62:0]))
          : (res_q[31] != $past(fs_q[31])
             && res_q[30:0] == $past(fs_q[30:0]));
  endproperty
  a_neg_sign: assert property (p_neg_sign) // [RQ13]
    else $error("negate changed more than the sign");

  property p_cpu;
    ex_go && !ctrl_q[CTRL_EN] && (is_lw || is_cop)
      |=> exc_q == EX_CPU && !wfpr_q && !wgpr_q;
  endproperty
  a_cpu: assert property (p_cpu) // [RQ14]
    else $error("disabled unit did not trap");

  property p_mul_flags;
    ex_go && is_mul && ctrl_q[CTRL_EN]
      |=> (flags_q & cause_q[4:0]) == cause_q[4:0]
          && (cause_q[CB_E] == (exc_q == EX_FPE))
          ##1 (exc_q == $past(exc_q));
  endproperty
  a_mul_flags: assert property (p_mul_flags) // [RQ11] [RQ15]
    else $error("multiply conditions not recorded");

  c_lw_ok:   cover property (ex_go && is_lw ##1 wfpr_q);
  c_adel:    cover property (ex_go ##1 exc_q == EX_ADEL);
  c_mul_inx: cover property (ex_go && is_mul ##1 cause_q[CB_I]);
endmodule

// ### testbench/fmx_host.sv
// AHB-Lite master standing in for the pipeline and memory path.
// Assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
module fmx_host (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  // Idle bus at time zero, word transfers only
  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // Bounded wait for hready at a rising edge; a hang ends the run
  task wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 32)
    begin
      @(posedge hclk);
      n++;
    end
    if (n >= 32)
    begin
      fmx_exec_bench.n_mismatch++;
      fmx_exec_bench.wrap_up();
    end
  endtask

  // One single transfer; called just after a rising edge
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    // Released data must not keep looking valid
    hwdata <= ~wd;
  endtask
endmodule

// ### testbench/fmx_exec_bench.sv
// Self-checking bench for the float move/load/multiply block.
// Assumes zero-wait register bus answers; polls busy with a bound.
`timescale 1ns/1ps
module fmx_exec_bench;
  import fmx_pkg::*;
  localparam logic [31:0] MUL_S = {OP_COP, FMT_S, 5'd1, 5'd2, 5'd4, FN_MUL};
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] lo;
  logic [31:0] hi;
  logic [31:0] st;
  logic [31:0] tmp;
  int          n_mismatch = 0;
  int          n_checks = 0;

  fmx_exec dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp));
  fmx_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));

  // 200 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task wrap_up();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, tmp);
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0, tmp);
    chk(tmp, exp);
  endtask

  // Issue one instruction, poll busy, fetch the result words
  task run(input logic [31:0] ins);
    int n;
    n = 0;
    wr(A_INSTR, ins);
    st = 32'h1;
    while (st[0] !== 1'b0 && n < 16)
    begin
      host.xfer(1'b0, A_STATUS, 32'h0, st);
      n++;
    end
    if (st[0] !== 1'b0)
    begin
      n_mismatch++;
      wrap_up();
    end
    host.xfer(1'b0, A_RES_LO, 32'h0, lo);
    host.xfer(1'b0, A_RES_HI, 32'h0, hi);
  endtask

  task exc(input logic [2:0] e);
    chk({29'h0, st[10:8]}, {29'h0, e});
  endtask

  // Expected status: {int,float} write flags, index, exception, pad
  function automatic logic [31:0] sv(logic [1:0] w, logic [4:0] ix,
                                     logic [2:0] e, logic [2:0] pd);
    return {17'h0, pd, 1'b0, e, ix, w, 1'b0};
  endfunction

  initial
  begin
    hresetn = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    // Reset values, an unmapped place, response code
    rchk(A_CTRL, 32'h0);
    rchk(A_FCSR, 32'h0);
    rchk(A_STATUS, 32'h0);
    rchk(8'h40, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    // Disabled unit refuses, then exact product once enabled
    wr(A_FS_LO, 32'h40000000);
    wr(A_FT_LO, 32'h40400000);
    run(MUL_S);
    exc(EX_CPU);
    wr(A_CTRL, 32'h1);
    run(MUL_S);
    chk(lo, 32'h40C00000);
    chk(st & 32'h7FF, sv(2'b01, 5'd4, EX_NONE, 3'h0));
    rchk(A_FCSR, 32'h0);
    // Word load under every endian combination; -4 offset tests sign
    wr(A_GPR_LO, 32'h00000100);
    wr(A_MEM_LO, 32'h11111111);
    wr(A_MEM_HI, 32'h22222222);
    for (int c = 1; c < 8; c += 2)
    begin
      wr(A_CTRL, 32'(c));
      run({OP_LWF, 5'd1, 5'd5, 16'hFFFC});
      chk(lo, c[1] ? 32'h11111111 : 32'h22222222);
      chk(hi, 32'h0);
      chk(st, sv(2'b01, 5'd5, EX_NONE, {~c[2], 2'b00}));
      rchk(A_EA_LO, 32'h000000FC);
      rchk(A_EA_HI, 32'h0);
    end
    // Misaligned word loads
    for (int k = 1; k < 4; k++)
    begin
      run({OP_LWF, 5'd1, 5'd5, 16'(k)});
      exc(EX_ADEL);
    end
    // Word moves both ways, with a bad tail
    wr(A_FS_LO, 32'h80000001);
    run({OP_COP, SUB_MF, 5'd7, 5'd2, 11'h000});
    chk(lo, 32'h80000001);
    chk(hi, 32'hFFFFFFFF);
    chk(st & 32'h7FF, sv(2'b10, 5'd7, EX_NONE, 3'h0));
    run({OP_COP, SUB_MF, 5'd7, 5'd2, 11'h001});
    exc(EX_RI);
    wr(A_GPR_LO, 32'h12345678);
    wr(A_GPR_HI, 32'h9ABCDEF0);
    run({OP_COP, SUB_MT, 5'd1, 5'd9, 11'h000});
    chk(lo, 32'h12345678);
    chk(hi, 32'h0);
    chk(st & 32'h7FF, sv(2'b01, 5'd9, EX_NONE, 3'h0));
    // Copy of a NaN raises nothing; nonzero field 20..16 refused
    wr(A_FS_LO, 32'h7FC00001);
    run({OP_COP, FMT_S, 5'd0, 5'd2, 5'd3, FN_MOV});
    chk(lo, 32'h7FC00001);
    chk(st & 32'h7FF, sv(2'b01, 5'd3, EX_NONE, 3'h0));
    rchk(A_FCSR, 32'h0);
    run({OP_COP, FMT_S, 5'd1, 5'd2, 5'd3, FN_MOV});
    exc(EX_RI);
    // Negate of a NaN flips sign and flags invalid
    run({OP_COP, FMT_S, 5'd0, 5'd2, 5'd3, FN_NEG});
    chk(lo, 32'hFFC00001);
    rchk(A_FCSR, 32'h00010040);
    // Inexact product under each rounding mode
    wr(A_FS_LO, 32'h3F800001);
    wr(A_FT_LO, 32'h3F800001);
    for (int m = 0; m < 4; m++)
    begin
      wr(A_FCSR, 32'(m));
      run(MUL_S);
      chk(lo, (m == 2) ? 32'h3F800003 : 32'h3F800002);
      rchk(A_FCSR, 32'h00001004 | 32'(m));
    end
    // Invalid and overflow products
    wr(A_FCSR, 32'h0);
    wr(A_FS_LO, 32'h7FC00000);
    run(MUL_S);
    chk(lo, 32'h7FBFFFFF);
    rchk(A_FCSR, 32'h00010040);
    wr(A_FCSR, 32'h0);
    wr(A_FS_LO, 32'h7F000000);
    wr(A_FT_LO, 32'h7F000000);
    run(MUL_S);
    chk(lo, 32'h7F800000);
    rchk(A_FCSR, 32'h00005014);
    // Double format product, then a bad format
    wr(A_FS_HI, 32'h40000000);
    wr(A_FS_LO, 32'h0);
    wr(A_FT_HI, 32'h40080000);
    wr(A_FT_LO, 32'h0);
    run({OP_COP, FMT_D, 5'd1, 5'd2, 5'd4, FN_MUL});
    chk(hi, 32'h40180000);
    chk(lo, 32'h0);
    // Result words are read only; a bad format is then refused as reserved
    wr(A_RES_HI, 32'hFFFFFFFF);
    rchk(A_RES_HI, 32'h40180000);
    run({OP_COP, 5'h14, 5'd1, 5'd2, 5'd4, FN_MUL});
    exc(EX_RI);
    wrap_up();
  end
endmodule
